// ===== shared/dvr_consts.svh
// Constants shared by both ends of the playback volume and routing link
`ifndef DVR_CONSTS_SVH
`define DVR_CONSTS_SVH

// Sample and register widths
`define DVR_SW 16
`define DVR_RW 8

// Device register map
`define DVR_ADDR_PATH 8'h3F
`define DVR_ADDR_MUTE 8'h40
`define DVR_ADDR_GAIN_L 8'h41
`define DVR_ADDR_GAIN_R 8'h42
`define DVR_ADDR_DRC 8'h44

// Reset values
`define DVR_RST_PATH 8'h14
`define DVR_RST_MUTE 8'h0C
`define DVR_RST_GAIN 8'h00
`define DVR_RST_DRC 8'h0F
`define DVR_RDATA_NONE 8'h00

// Field positions
`define DVR_PATH_PWR_L 7
`define DVR_PATH_PWR_R 6
`define DVR_PATH_SRC_L_LSB 4
`define DVR_PATH_SRC_R_LSB 2
`define DVR_PATH_STEP_LSB 0
`define DVR_MUTE_L 3
`define DVR_MUTE_R 2
`define DVR_MUTE_COUP_LSB 0
`define DVR_MUTE_RSVD_LSB 4
`define DVR_DRC_EN_L 6
`define DVR_DRC_EN_R 5

// Field codes
`define DVR_SRC_OFF 2'h0
`define DVR_SRC_OWN 2'h1
`define DVR_SRC_SWAP 2'h2
`define DVR_SRC_MIX 2'h3
`define DVR_STEP_EVERY 2'h0
`define DVR_STEP_HALF 2'h1
`define DVR_STEP_NONE 2'h2
`define DVR_STEP_RSVD 2'h3
`define DVR_COUP_INDEP 2'h0
`define DVR_COUP_L_FROM_R 2'h1
`define DVR_COUP_R_FROM_L 2'h2
`define DVR_RSVD_NIBBLE 4'h0

// Gain code limits
`define DVR_GAIN_MAX 8'h30
`define DVR_GAIN_MIN 8'h81
`define DVR_GAIN_RSVD 8'h80
`define DVR_GAIN_STEP 8'h01

// Host Wishbone map
`define DVR_WB_CMD 32'h0000_0000
`define DVR_WB_STATUS 32'h0000_0004
`define DVR_WB_SEL_ALL 4'hF
`define DVR_WB_ZERO 32'h0000_0000
`define DVR_CMD_DATA_LSB 0
`define DVR_CMD_ADDR_LSB 8
`define DVR_CMD_WE 16
`define DVR_STAT_BUSY 0
`define DVR_STAT_RDATA_LSB 8

`endif

// ===== shared/dvr_pkg.sv
// Types shared by both ends of the playback volume and routing link
`include "dvr_consts.svh"
package dvr_pkg;
   typedef logic signed [`DVR_SW-1:0] dvr_sample_t;
   typedef logic [`DVR_RW-1:0] dvr_byte_t;
   typedef logic signed [`DVR_RW-1:0] dvr_gain_t;
   typedef enum logic {
      DVR_IDLE = 1'b0,
      DVR_BUSY = 1'b1
   } dvr_host_state_t;
endpackage

// ===== shared/dvr_link_if.sv
// Register access and sample stream between the host end and the device end
`timescale 1ns/1ps
`include "dvr_consts.svh"
interface dvr_link_if;
   logic reg_req;
   logic reg_we;
   logic [`DVR_RW-1:0] reg_addr;
   logic [`DVR_RW-1:0] reg_wdata;
   logic [`DVR_RW-1:0] reg_rdata;
   logic reg_ack;
   logic smp_valid;
   logic [`DVR_SW-1:0] smp_left;
   logic [`DVR_SW-1:0] smp_right;

   modport dev (
      input reg_req,
      input reg_we,
      input reg_addr,
      input reg_wdata,
      output reg_rdata,
      output reg_ack,
      input smp_valid,
      input smp_left,
      input smp_right
   );

   modport host (
      output reg_req,
      output reg_we,
      output reg_addr,
      output reg_wdata,
      input reg_rdata,
      input reg_ack,
      output smp_valid,
      output smp_left,
      output smp_right
   );
endinterface

// ===== rtl/dvr_device.sv
// Device end: register file, source routing, mute and soft-stepped gain
//
// Implementation choice: the dvr_link_if dev modport; the Wishbone slave port is in dvr_host.
`timescale 1ns/1ps
`include "dvr_consts.svh"
module dvr_device (
   input wire logic clk_sys,
   input wire logic rst,
   dvr_link_if.dev link,
   output logic [1:0] chan_power,
   output logic [1:0] chan_mute,
   output logic [1:0] chan_valid,
   output logic [1:0][`DVR_SW-1:0] chan_sample,
   output logic [1:0][`DVR_RW-1:0] chan_gain
);

   dvr_pkg::dvr_byte_t path_setup;
   dvr_pkg::dvr_byte_t mute_coupling;
   dvr_pkg::dvr_byte_t gain_reg [2];
   dvr_pkg::dvr_byte_t compressor_ctl;
   dvr_pkg::dvr_byte_t rdata;
   logic ack;
   dvr_pkg::dvr_byte_t next_path_setup;
   dvr_pkg::dvr_byte_t next_mute_coupling;
   dvr_pkg::dvr_byte_t next_gain_reg [2];
   dvr_pkg::dvr_byte_t next_compressor_ctl;
   dvr_pkg::dvr_byte_t next_rdata;
   logic next_ack;

   // Register port: one request, one ack a cycle later
   always_comb begin
      next_path_setup = path_setup;
      next_mute_coupling = mute_coupling;
      next_gain_reg = gain_reg;
      next_compressor_ctl = compressor_ctl;
      next_rdata = rdata;
      next_ack = 1'b0;
      if (link.reg_req && !ack) begin
         next_ack = 1'b1;
         case (link.reg_addr)
            `DVR_ADDR_PATH: begin
               next_rdata = path_setup;
               if (link.reg_we) begin
                  next_path_setup = link.reg_wdata;
               end
            end
            `DVR_ADDR_MUTE: begin
               next_rdata = mute_coupling;
               if (link.reg_we) begin
                  next_mute_coupling = link.reg_wdata;
               end
            end
            `DVR_ADDR_GAIN_L: begin
               next_rdata = gain_reg[0];
               if (link.reg_we) begin
                  next_gain_reg[0] = link.reg_wdata;
               end
            end
            `DVR_ADDR_GAIN_R: begin
               next_rdata = gain_reg[1];
               if (link.reg_we) begin
                  next_gain_reg[1] = link.reg_wdata;
               end
            end
            `DVR_ADDR_DRC: begin
               next_rdata = compressor_ctl;
               if (link.reg_we) begin
                  next_compressor_ctl = link.reg_wdata;
               end
            end
            default: begin
               // Unmapped: acked, reads zero, write dropped
               next_rdata = `DVR_RDATA_NONE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         path_setup <= `DVR_RST_PATH;
         mute_coupling <= `DVR_RST_MUTE;
         gain_reg[0] <= `DVR_RST_GAIN;
         gain_reg[1] <= `DVR_RST_GAIN;
         compressor_ctl <= `DVR_RST_DRC;
         rdata <= `DVR_RDATA_NONE;
         ack <= 1'b0;
      end else begin
         path_setup <= next_path_setup;
         mute_coupling <= next_mute_coupling;
         gain_reg <= next_gain_reg;
         compressor_ctl <= next_compressor_ctl;
         rdata <= next_rdata;
         ack <= next_ack;
      end
   end

   assign link.reg_ack = ack;
   assign link.reg_rdata = rdata;

   // Step pacing shared by both channels
   logic step_phase;
   logic next_step_phase;
   logic step_tick;
   logic step_bypass;
   logic [1:0] step_mode;
   logic drc_on;
   logic [1:0] coup_mode;

   always_comb begin
      step_mode = path_setup[`DVR_PATH_STEP_LSB +: 2];
      coup_mode = mute_coupling[`DVR_MUTE_COUP_LSB +: 2];
      drc_on = compressor_ctl[`DVR_DRC_EN_L] | compressor_ctl[`DVR_DRC_EN_R];
      next_step_phase = step_phase;
      if (link.smp_valid) begin
         next_step_phase = !step_phase;
      end
      step_tick = 1'b0;
      step_bypass = 1'b1;
      case (step_mode)
         `DVR_STEP_EVERY: begin
            step_tick = link.smp_valid;
            step_bypass = 1'b0;
         end
         `DVR_STEP_HALF: begin
            step_tick = link.smp_valid && step_phase;
            step_bypass = 1'b0;
         end
         default: begin
            // Reserved code acts as no stepping, so gain never stalls
            step_bypass = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         step_phase <= 1'b0;
      end else begin
         step_phase <= next_step_phase;
      end
   end

   // Per channel: routing, mute, power and gain ramp
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic pwr;
         logic mute;
         logic [1:0] src;
         logic coupled;
         dvr_pkg::dvr_sample_t own;
         dvr_pkg::dvr_sample_t other;
         dvr_pkg::dvr_sample_t routed;
         logic signed [`DVR_SW:0] sum;
         dvr_pkg::dvr_gain_t target;
         dvr_pkg::dvr_gain_t applied;
         dvr_pkg::dvr_gain_t next_applied;
         dvr_pkg::dvr_sample_t smp_q;
         dvr_pkg::dvr_sample_t next_smp_q;
         logic valid_q;
         logic next_valid_q;
         logic pwr_q;
         logic mute_q;

         always_comb begin
            pwr = (ch == 0) ? path_setup[`DVR_PATH_PWR_L] :
               path_setup[`DVR_PATH_PWR_R];
            mute = (ch == 0) ? mute_coupling[`DVR_MUTE_L] :
               mute_coupling[`DVR_MUTE_R];
            src = (ch == 0) ? path_setup[`DVR_PATH_SRC_L_LSB +: 2] :
               path_setup[`DVR_PATH_SRC_R_LSB +: 2];
            own = (ch == 0) ? link.smp_left : link.smp_right;
            other = (ch == 0) ? link.smp_right : link.smp_left;
            // Widened sum so the average cannot overflow
            sum = {own[`DVR_SW-1], own} + {other[`DVR_SW-1], other};
            case (src)
               `DVR_SRC_OWN: routed = own;
               `DVR_SRC_SWAP: routed = other;
               `DVR_SRC_MIX: routed = sum[`DVR_SW:1];
               default: routed = '0;
            endcase
            // Compressor overrides coupling regardless of field value
            coupled = !drc_on &&
               (coup_mode == ((ch == 0) ? `DVR_COUP_L_FROM_R : `DVR_COUP_R_FROM_L));
            target = coupled ? gain_reg[1 - ch] : gain_reg[ch];
            next_applied = applied;
            if (step_bypass) begin
               next_applied = target;
            end else if (step_tick && applied != target) begin
               next_applied = (applied < target) ? applied + `DVR_GAIN_STEP :
                  applied - `DVR_GAIN_STEP;
            end
            next_smp_q = smp_q;
            next_valid_q = 1'b0;
            if (link.smp_valid) begin
               next_valid_q = pwr;
               next_smp_q = (pwr && !mute) ? routed : '0;
            end
         end

         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               applied <= `DVR_RST_GAIN;
               smp_q <= '0;
               valid_q <= 1'b0;
               pwr_q <= 1'b0;
               mute_q <= 1'b1;
            end else begin
               applied <= next_applied;
               smp_q <= next_smp_q;
               valid_q <= next_valid_q;
               pwr_q <= pwr;
               mute_q <= mute;
            end
         end

         assign chan_power[ch] = pwr_q;
         assign chan_mute[ch] = mute_q;
         assign chan_valid[ch] = valid_q;
         assign chan_sample[ch] = smp_q;
         assign chan_gain[ch] = applied;
      end
   endgenerate

endmodule

// ===== rtl/dvr_host.sv
// Host end: Wishbone command registers, register access master, sample feed
`timescale 1ns/1ps
`include "dvr_consts.svh"
module dvr_host (
   input wire logic clk_sys,
   input wire logic rst,
   dvr_link_if.host link,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic src_valid,
   input wire logic [`DVR_SW-1:0] src_left,
   input wire logic [`DVR_SW-1:0] src_right
);

   // Keeps the device clear of reserved and forbidden codes
   function automatic dvr_pkg::dvr_byte_t dvr_clean(input dvr_pkg::dvr_byte_t a,
         input dvr_pkg::dvr_byte_t d, input logic dynamic_range_compressor);
      dvr_pkg::dvr_byte_t r;
      r = d;
      case (a)
         `DVR_ADDR_PATH: begin
            if (r[`DVR_PATH_STEP_LSB +: 2] == `DVR_STEP_RSVD) begin
               r[`DVR_PATH_STEP_LSB +: 2] = `DVR_STEP_NONE;
            end
         end
         `DVR_ADDR_MUTE: begin
            r[`DVR_MUTE_RSVD_LSB +: 4] = `DVR_RSVD_NIBBLE;
            if (dynamic_range_compressor) begin
               r[`DVR_MUTE_COUP_LSB +: 2] = `DVR_COUP_INDEP;
            end
         end
         `DVR_ADDR_GAIN_L, `DVR_ADDR_GAIN_R: begin
            if (r == `DVR_GAIN_RSVD) begin
               r = `DVR_GAIN_MIN;
            end else if (!r[`DVR_RW-1] && r > `DVR_GAIN_MAX) begin
               r = `DVR_GAIN_MAX;
            end
         end
         default: begin
            r = d;
         end
      endcase
      return r;
   endfunction

   dvr_pkg::dvr_host_state_t state;
   dvr_pkg::dvr_host_state_t next_state;
   logic req;
   logic next_req;
   logic we;
   logic next_we;
   dvr_pkg::dvr_byte_t addr;
   dvr_pkg::dvr_byte_t next_addr;
   dvr_pkg::dvr_byte_t wdata;
   dvr_pkg::dvr_byte_t next_wdata;
   dvr_pkg::dvr_byte_t rdata;
   dvr_pkg::dvr_byte_t next_rdata;
   logic drc_seen;
   logic next_drc_seen;
   logic ack;
   logic next_ack;
   logic [31:0] dat;
   logic [31:0] next_dat;
   logic smp_valid;
   logic [`DVR_SW-1:0] smp_left;
   logic [`DVR_SW-1:0] smp_right;
   logic wb_req;
   dvr_pkg::dvr_byte_t cmd_addr;

   always_comb begin
      next_state = state;
      next_req = req;
      next_we = we;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_drc_seen = drc_seen;
      next_ack = 1'b0;
      next_dat = dat;
      wb_req = wb_cyc_i && wb_stb_i && !ack;
      cmd_addr = wb_dat_i[`DVR_CMD_ADDR_LSB +: `DVR_RW];
      if (wb_req) begin
         next_ack = 1'b1;
         next_dat = `DVR_WB_ZERO;
         if (wb_adr_i == `DVR_WB_CMD) begin
            next_dat[`DVR_CMD_DATA_LSB +: `DVR_RW] = wdata;
            next_dat[`DVR_CMD_ADDR_LSB +: `DVR_RW] = addr;
            next_dat[`DVR_CMD_WE] = we;
         end else if (wb_adr_i == `DVR_WB_STATUS) begin
            next_dat[`DVR_STAT_BUSY] = (state == dvr_pkg::DVR_BUSY);
            next_dat[`DVR_STAT_RDATA_LSB +: `DVR_RW] = rdata;
         end
      end
      case (state)
         dvr_pkg::DVR_IDLE: begin
            // Commands while busy are dropped, software polls busy first
            if (wb_req && wb_we_i && wb_adr_i == `DVR_WB_CMD && wb_sel_i == `DVR_WB_SEL_ALL) begin
               next_we = wb_dat_i[`DVR_CMD_WE];
               next_addr = cmd_addr;
               next_wdata = wb_dat_i[`DVR_CMD_DATA_LSB +: `DVR_RW];
               if (wb_dat_i[`DVR_CMD_WE]) begin
                  next_wdata = dvr_clean(cmd_addr, wb_dat_i[`DVR_CMD_DATA_LSB +: `DVR_RW],
                     drc_seen);
                  if (cmd_addr == `DVR_ADDR_DRC) begin
                     next_drc_seen = wb_dat_i[`DVR_DRC_EN_L] | wb_dat_i[`DVR_DRC_EN_R];
                  end
               end
               next_req = 1'b1;
               next_state = dvr_pkg::DVR_BUSY;
            end
         end
         dvr_pkg::DVR_BUSY: begin
            if (link.reg_ack) begin
               next_req = 1'b0;
               if (!we) begin
                  next_rdata = link.reg_rdata;
               end
               next_state = dvr_pkg::DVR_IDLE;
            end
         end
         default: begin
            next_req = 1'b0;
            next_state = dvr_pkg::DVR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= dvr_pkg::DVR_IDLE;
         req <= 1'b0;
         we <= 1'b0;
         addr <= `DVR_RDATA_NONE;
         wdata <= `DVR_RDATA_NONE;
         rdata <= `DVR_RDATA_NONE;
         drc_seen <= 1'b0;
         ack <= 1'b0;
         dat <= `DVR_WB_ZERO;
         smp_valid <= 1'b0;
         smp_left <= '0;
         smp_right <= '0;
      end else begin
         state <= next_state;
         req <= next_req;
         we <= next_we;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         drc_seen <= next_drc_seen;
         ack <= next_ack;
         dat <= next_dat;
         smp_valid <= src_valid;
         smp_left <= src_left;
         smp_right <= src_right;
      end
   end

   assign link.reg_req = req;
   assign link.reg_we = we;
   assign link.reg_addr = addr;
   assign link.reg_wdata = wdata;
   assign link.smp_valid = smp_valid;
   assign link.smp_left = smp_left;
   assign link.smp_right = smp_right;
   assign wb_ack_o = ack;
   assign wb_dat_o = dat;

endmodule

// ===== testbench/dvr_link_monitor.sv
// Checker watching the register link between the host and device ends
`timescale 1ns/1ps
`include "dvr_consts.svh"
module dvr_link_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [`DVR_RW-1:0] reg_addr,
   input wire logic [`DVR_RW-1:0] reg_wdata,
   input wire logic [`DVR_RW-1:0] reg_rdata,
   input wire logic reg_ack
);
   // Shadow of device registers, slot 4 unused since 0x43 is unmapped
   logic [5:0][`DVR_RW-1:0] shd;
   logic [5:0][`DVR_RW-1:0] next_shd;

   always_comb begin
      next_shd = shd;
      if (reg_ack && reg_we && reg_addr >= `DVR_ADDR_PATH && reg_addr <= `DVR_ADDR_DRC) begin
         next_shd[3'(reg_addr - `DVR_ADDR_PATH)] = reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shd <= {`DVR_RST_DRC, 8'h00, `DVR_RST_GAIN, `DVR_RST_GAIN, `DVR_RST_MUTE, `DVR_RST_PATH};
      end else begin
         shd <= next_shd;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   chk_ack_next: assert property (reg_req && !reg_ack |=> reg_ack ##1 !reg_ack)
      else $error("link ack not one cycle after request");
   chk_req_hold: assert property (reg_req && !reg_ack |=>
      reg_req && $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata))
      else $error("link request changed before ack");
   chk_path_read: assert property (reg_ack && !reg_we && reg_addr == `DVR_ADDR_PATH
      |-> reg_rdata == shd[0])
      else $error("setup register read mismatch");
   chk_mute_read: assert property (reg_ack && !reg_we && reg_addr == `DVR_ADDR_MUTE
      |-> reg_rdata == shd[1])
      else $error("mute register read mismatch");
   chk_gainl_read: assert property (reg_ack && !reg_we && reg_addr == `DVR_ADDR_GAIN_L
      |-> reg_rdata == shd[2])
      else $error("left gain read mismatch");
   chk_gainr_read: assert property (reg_ack && !reg_we && reg_addr == `DVR_ADDR_GAIN_R
      |-> reg_rdata == shd[3])
      else $error("right gain read mismatch");
   chk_unmapped_read: assert property (reg_ack && !reg_we && !(reg_addr inside {8'h3F, 8'h40,
      8'h41, 8'h42, 8'h44}) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_step_legal: assert property (reg_req && reg_we && reg_addr == `DVR_ADDR_PATH
      |-> reg_wdata[1:0] != `DVR_STEP_RSVD)
      else $error("reserved step code sent");
   chk_gain_legal: assert property (reg_req && reg_we && reg_addr inside {8'h41, 8'h42}
      |-> !(reg_wdata inside {[8'h31:8'h80]}))
      else $error("illegal gain code sent");
   chk_mute_rsvd: assert property (reg_req && reg_we && reg_addr == `DVR_ADDR_MUTE
      |-> reg_wdata[7:4] == `DVR_RSVD_NIBBLE)
      else $error("reserved mute bits not zero");
   chk_coup_indep: assert property (reg_req && reg_we && reg_addr == `DVR_ADDR_MUTE
      && shd[5][6:5] != 2'b00 |-> reg_wdata[1:0] == `DVR_COUP_INDEP)
      else $error("coupling sent while compressor on");
endmodule

// ===== testbench/dac_volume_routing_control_tb_top.sv
// Bench joining host and device ends, driving Wishbone and samples
`timescale 1ns/1ps
`include "dvr_consts.svh"
module dac_volume_routing_control_tb_top;
   logic clk_sys, rst, wb_cyc, wb_stb, wb_we, wb_ack_o, src_valid;
   logic [31:0] wb_adr, wb_dat, wb_dat_o, q;
   logic [`DVR_SW-1:0] src_left, src_right;
   logic [1:0] chan_power, chan_mute, chan_valid;
   logic [1:0][`DVR_SW-1:0] chan_sample;
   logic [1:0][`DVR_RW-1:0] chan_gain;
   int err_total = 0;
   int n_tests = 0;

   dvr_link_if link_if();
   dvr_host dvr_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link_if), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
      .wb_sel_i(`DVR_WB_SEL_ALL), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .src_valid(src_valid), .src_left(src_left), .src_right(src_right));
   dvr_device dvr_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link_if),
      .chan_power(chan_power), .chan_mute(chan_mute), .chan_valid(chan_valid),
      .chan_sample(chan_sample), .chan_gain(chan_gain));
   dvr_link_monitor dvr_link_monitor_inst (.clk_sys(clk_sys), .rst(rst),
      .reg_req(link_if.reg_req), .reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr),
      .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata), .reg_ack(link_if.reg_ack));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Ack is read before this edge's updates land, so it is the answered cycle
   task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic dev_op(input logic we, input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, `DVR_WB_CMD, {15'h0, we, a, d});
      do wb(1'b0, `DVR_WB_STATUS, `DVR_WB_ZERO); while (q[`DVR_STAT_BUSY] !== 1'b0);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      dev_op(1'b0, a, 8'h00);
      check(q[15:8], exp);
   endtask

   // Returns at the edge where the channel strobe is still visible
   task automatic smp(input logic [15:0] l, input logic [15:0] r);
      src_left <= l;
      src_right <= r;
      src_valid <= 1'b1;
      @(posedge clk_sys);
      src_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   function automatic logic [15:0] route(input int s, input logic [15:0] own,
      input logic [15:0] oth);
      logic signed [16:0] sum;
      sum = $signed({own[15], own}) + $signed({oth[15], oth});
      case (s)
         0: return 16'h0000;
         1: return own;
         2: return oth;
         default: return sum[16:1];
      endcase
   endfunction

   initial begin
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, src_valid} = 4'h0;
      {wb_adr, wb_dat, src_left, src_right} = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check(chan_power, 2'b00);
      check(chan_mute, 2'b11);
      rd_chk(`DVR_ADDR_PATH, `DVR_RST_PATH);
      rd_chk(`DVR_ADDR_MUTE, `DVR_RST_MUTE);
      rd_chk(`DVR_ADDR_GAIN_L, `DVR_RST_GAIN);
      rd_chk(`DVR_ADDR_GAIN_R, `DVR_RST_GAIN);
      rd_chk(8'h50, 8'h00);
      wb(1'b0, 32'h0000_0008, `DVR_WB_ZERO);
      check(q, 32'h0000_0000);
      smp(16'h1234, 16'h5678);
      check(chan_valid, 2'b00);
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'h00);
      for (int s = 0; s < 4; s++) begin
         dev_op(1'b1, `DVR_ADDR_PATH, {2'b11, s[1:0], s[1:0], `DVR_STEP_NONE});
         smp(16'hFFFB, 16'h0002);
         check(chan_valid, 2'b11);
         check(chan_sample[0], route(s, 16'hFFFB, 16'h0002));
         check(chan_sample[1], route(s, 16'h0002, 16'hFFFB));
      end
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'h08);
      dev_op(1'b1, `DVR_ADDR_PATH, 8'h96);
      smp(16'h0100, 16'h0200);
      check({chan_mute, chan_valid}, 4'b0101);
      check(chan_sample, 32'h0000_0000);
      check(chan_power, 2'b01);
      dev_op(1'b1, `DVR_ADDR_PATH, 8'hD6);
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'h00);
      dev_op(1'b1, `DVR_ADDR_GAIN_L, `DVR_GAIN_MAX);
      dev_op(1'b1, `DVR_ADDR_GAIN_R, `DVR_GAIN_MIN);
      check(chan_gain, 16'h8130);
      for (int c = 0; c < 4; c++) begin
         dev_op(1'b1, `DVR_ADDR_MUTE, {6'h00, c[1:0]});
         check(chan_gain, c == 1 ? 16'h8181 : c == 2 ? 16'h3030 : 16'h8130);
      end
      for (int k = 0; k < 2; k++) begin
         dev_op(1'b1, `DVR_ADDR_DRC, k == 0 ? 8'h4F : 8'h2F);
         dev_op(1'b1, `DVR_ADDR_MUTE, 8'h01);
         rd_chk(`DVR_ADDR_MUTE, 8'h00);
         check(chan_gain, 16'h8130);
      end
      // Coupling set before the compressor turns on; device must override it
      dev_op(1'b1, `DVR_ADDR_DRC, `DVR_RST_DRC);
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'h01);
      check(chan_gain, 16'h8181);
      dev_op(1'b1, `DVR_ADDR_DRC, 8'h4F);
      check(chan_gain, 16'h8130);
      dev_op(1'b1, `DVR_ADDR_DRC, `DVR_RST_DRC);
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'h00);
      dev_op(1'b1, `DVR_ADDR_GAIN_L, 8'h45);
      rd_chk(`DVR_ADDR_GAIN_L, `DVR_GAIN_MAX);
      dev_op(1'b1, `DVR_ADDR_GAIN_R, `DVR_GAIN_RSVD);
      rd_chk(`DVR_ADDR_GAIN_R, `DVR_GAIN_MIN);
      dev_op(1'b1, `DVR_ADDR_MUTE, 8'hF0);
      rd_chk(`DVR_ADDR_MUTE, 8'h00);
      dev_op(1'b1, `DVR_ADDR_PATH, 8'hD7);
      rd_chk(`DVR_ADDR_PATH, 8'hD6);
      // Stepping from zero up to a small target, one code per sample
      dev_op(1'b1, `DVR_ADDR_GAIN_L, 8'h00);
      dev_op(1'b1, `DVR_ADDR_PATH, 8'hD4);
      dev_op(1'b1, `DVR_ADDR_GAIN_L, 8'h03);
      check(chan_gain[0], 8'h00);
      for (int i = 1; i < 5; i++) begin
         smp(16'h0010, 16'h0020);
         check(chan_gain[0], i < 3 ? i : 3);
      end
      // Half rate crosses zero; any phase gives one step per two samples
      dev_op(1'b1, `DVR_ADDR_PATH, 8'hD5);
      dev_op(1'b1, `DVR_ADDR_GAIN_L, 8'hFE);
      for (int i = 1; i < 6; i++) begin
         smp(16'h0010, 16'h0020);
         smp(16'h0011, 16'h0021);
         check(chan_gain, {`DVR_GAIN_MIN, 8'(3 - i)});
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check({chan_power, chan_mute, chan_gain}, 20'h3_0000);
      rd_chk(`DVR_ADDR_PATH, `DVR_RST_PATH);
      complete_run;
   end

   initial begin
      repeat (6000) @(posedge clk_sys);
      err_total++;
      complete_run;
   end
endmodule
